// >>> rtl/sys_bank_cfg.svh
// Offsets, field positions, reset values and keys of the configuration bank
`ifndef SYS_BANK_CFG_SVH
`define SYS_BANK_CFG_SVH
`define OFF_BANDGAP      16'h2300
`define OFF_BANDGAP_CLR  16'h2304
`define OFF_BANDGAP_SET  16'h2308
`define OFF_BANDGAP_INV  16'h230c
`define OFF_CFG_CTRL     16'h3640
`define OFF_IDENTITY     16'h3660
`define OFF_UNLOCK_KEY   16'h3670
`define OFF_OSC_BOOT     16'h3680
`define OFF_CODE_PROT    16'h3684
`define BG_CONV_BIT      2
`define BG_CMP_BIT       1
`define CFG_ERRDIS_BIT   27
`define CFG_ARB_HI       25
`define CFG_ARB_LO       24
`define CFG_EXEC_HI      23
`define CFG_EXEC_LO      16
`define CFG_JTAG_BIT     3
`define CFG_RSVD_HI      1
`define CFG_RSVD_LO      0
`define CFG_RSVD_VAL     2'h3
`define KEY_FIRST        32'haa996655
`define KEY_SECOND       32'h556699aa
`define KEY_STATUS_BIT   0
`define OSC_CKSM_HI      15
`define OSC_CKSM_LO      14
`define OSC_SECONDARY_OSCILLATOR_SRC     12
`define OSC_CLOCK_OUTPUT_PIN_FN      10
`define OSC_PMODE_HI     9
`define OSC_PMODE_LO     8
`define OSC_TWO_SPEED    7
`define OSC_SECONDARY_OSCILLATOR_EN      6
`define OSC_PLL_SRC      4
`define OSC_SEL_HI       2
`define OSC_SEL_LO       0
`define CP_BIT           31
`define RAM_BASE_ADDR    32'ha0000000
`define RAM_STEP_ZEROS   10'h000
`define ARB_RESERVED     2'h3
`endif

// >>> rtl/sys_bank_pkg.sv
// Types shared by the configuration bank modules
package sys_bank_pkg;
    typedef enum logic [1:0] {
        PRI_EXT_CLOCK = 2'h0, PRI_MEDIUM_XTAL = 2'h1,
        PRI_HIGH_XTAL = 2'h2, PRI_DISABLED = 2'h3
    } primary_osc_mode_e;
    typedef enum logic [2:0] {
        SRC_FAST_RC_DIV = 3'h0, SRC_PLL = 3'h1, SRC_PRIMARY = 3'h2,
        SRC_SECONDARY = 3'h4, SRC_LOW_POWER_RC = 3'h5
    } reset_clock_e;
    typedef enum logic [1:0] {
        ARB_CPU_HIGHEST = 2'h0, ARB_CPU_LOWEST = 2'h1, ARB_ROUND_ROBIN = 2'h2
    } arbitration_e;
    // Gray order along locked, first key seen, unlocked
    typedef enum logic [1:0] {
        KEY_LOCKED = 2'h0, KEY_FIRST_SEEN = 2'h1, KEY_UNLOCKED = 2'h3
    } unlock_state_e;
    typedef struct packed {
        logic              clock_switch_en;
        logic              fail_safe_en;
        logic              secondary_oscillator_crystal;
        logic              clock_output_en;
        primary_osc_mode_e primary_osc_mode;
        logic              dual_speed_startup;
        logic              secondary_osc_enable;
        logic              pll_from_fast_rc;
        reset_clock_e      reset_clock;
        logic              code_protect_on;
    } boot_decode_s;
endpackage

// >>> rtl/bank_link_if.sv
// Signals between the bank, the unlock sequencer and the boot word decoder
`timescale 1ns/1ps
interface bank_link_if;
    logic                       key_write;
    logic [31:0]                key_data;
    logic                       unlocked;
    logic [31:0]                osc_word;
    logic [31:0]                prot_word;
    sys_bank_pkg::boot_decode_s decoded;
    modport bank (output key_write, key_data, osc_word, prot_word,
                  input unlocked, decoded);
    modport unlock (input key_write, key_data, output unlocked);
    modport decode (input osc_word, prot_word, output decoded);
endinterface

// >>> rtl/unlock_sequencer.sv
// Two-word key sequence that opens the protected registers
`timescale 1ns/1ps
`include "sys_bank_cfg.svh"
module unlock_sequencer (
    input  wire logic   pclk,
    input  wire logic   presetn,
    bank_link_if.unlock link
);
    typedef struct packed {
        sys_bank_pkg::unlock_state_e st;
    } seq_s;
    seq_s cur;
    seq_s next_cur;

    always_comb begin
        next_cur = cur;
        if (link.key_write) begin
            case (cur.st)
                sys_bank_pkg::KEY_LOCKED, sys_bank_pkg::KEY_UNLOCKED: begin
                    if (link.key_data == `KEY_FIRST)
                        next_cur.st = sys_bank_pkg::KEY_FIRST_SEEN;
                    else
                        next_cur.st = sys_bank_pkg::KEY_LOCKED;
                end
                sys_bank_pkg::KEY_FIRST_SEEN: begin
                    if (link.key_data == `KEY_SECOND)
                        next_cur.st = sys_bank_pkg::KEY_UNLOCKED;
                    else
                        next_cur.st = sys_bank_pkg::KEY_LOCKED;
                end
                default: next_cur.st = sys_bank_pkg::KEY_LOCKED;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur.st <= sys_bank_pkg::KEY_UNLOCKED;
        end else begin
            cur <= next_cur;
        end
    end

    assign link.unlocked = (cur.st == sys_bank_pkg::KEY_UNLOCKED);
endmodule

// >>> rtl/boot_word_decoder.sv
// Decodes the nonvolatile oscillator and code-protect words
`timescale 1ns/1ps
`include "sys_bank_cfg.svh"
module boot_word_decoder (
    bank_link_if.decode link
);
    logic [2:0] sel;
    assign sel = link.osc_word[`OSC_SEL_HI:`OSC_SEL_LO];

    always_comb begin
        link.decoded.clock_switch_en = link.osc_word[`OSC_CKSM_HI];
        link.decoded.fail_safe_en    = link.osc_word[`OSC_CKSM_LO];
        link.decoded.secondary_oscillator_crystal    = link.osc_word[`OSC_SECONDARY_OSCILLATOR_SRC];
        link.decoded.clock_output_en = !link.osc_word[`OSC_CLOCK_OUTPUT_PIN_FN];
        link.decoded.primary_osc_mode = sys_bank_pkg::primary_osc_mode_e'(
            link.osc_word[`OSC_PMODE_HI:`OSC_PMODE_LO]);
        link.decoded.dual_speed_startup   = link.osc_word[`OSC_TWO_SPEED];
        link.decoded.secondary_osc_enable = link.osc_word[`OSC_SECONDARY_OSCILLATOR_EN];
        link.decoded.pll_from_fast_rc     = link.osc_word[`OSC_PLL_SRC];
        case (sel)
            3'h1:    link.decoded.reset_clock = sys_bank_pkg::SRC_PLL;
            3'h2:    link.decoded.reset_clock = sys_bank_pkg::SRC_PRIMARY;
            3'h4:    link.decoded.reset_clock = sys_bank_pkg::SRC_SECONDARY;
            3'h5:    link.decoded.reset_clock =
                         sys_bank_pkg::SRC_LOW_POWER_RC;
            // Reserved codes fall back to the divided fast RC
            default: link.decoded.reset_clock =
                         sys_bank_pkg::SRC_FAST_RC_DIV;
        endcase
        link.decoded.code_protect_on = !link.prot_word[`CP_BIT];
    end
endmodule

// >>> rtl/system_config_unlock_bank.sv
// System configuration bank: APB registers, key unlock and boot options
`timescale 1ns/1ps
`include "sys_bank_cfg.svh"
module system_config_unlock_bank #(
    parameter int          ADDR_W        = 16,
    // Arbitrary identity values, fixed per build variant
    parameter logic [3:0]  REVISION_CODE = 4'h1,
    parameter logic [27:0] PART_CODE     = 28'h0000abc
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [ADDR_W-1:0]          paddr,
    input  wire logic [31:0]                pwdata,
    input  wire logic [3:0]                 pstrb,
    output logic [31:0]                     prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic [31:0]                osc_boot_word,
    input  wire logic [31:0]                code_protect_word,
    input  wire logic                       debug_port_strap,
    input  wire logic                       conv_bandgap_hw_set,
    input  wire logic                       conv_bandgap_hw_clear,
    input  wire logic                       cmp_bandgap_hw_set,
    input  wire logic                       cmp_bandgap_hw_clear,
    output logic                            clock_switch_enable,
    output logic                            fail_safe_monitor_enable,
    output logic                            secondary_osc_crystal,
    output logic                            clock_output_enable,
    output sys_bank_pkg::primary_osc_mode_e primary_osc_mode,
    output logic                            dual_speed_startup,
    output logic                            secondary_osc_enable,
    output logic                            pll_source_select,
    output sys_bank_pkg::reset_clock_e      oscillator_selection,
    output logic                            code_protect_active,
    output logic                            bus_error_exception_enable,
    output sys_bank_pkg::arbitration_e      bus_arbitration_mode,
    output logic [31:0]                     ram_program_base,
    output logic                            debug_port_enable,
    output logic                            converter_bandgap_enable,
    output logic                            comparator_bandgap_enable,
    output logic                            system_unlocked
);
    generate
        if (ADDR_W < 16) begin : g_addr_check
            $error("ADDR_W must reach the highest register offset");
        end
    endgenerate

    typedef struct packed {
        logic [31:0] rdata;
        logic        conv_bg;
        logic        cmp_bg;
        logic        err_dis;
        logic [1:0]  arb;
        logic [7:0]  exec;
        logic        jtag;
        logic        strap_done;
        logic [31:0] ram_base;
        sys_bank_pkg::boot_decode_s boot;
    } bank_s;

    bank_s cur;
    bank_s next_cur;

    bank_link_if link ();

    unlock_sequencer u_unlock (
        .pclk    (pclk),
        .presetn (presetn),
        .link    (link.unlock)
    );

    boot_word_decoder u_decode (
        .link (link.decode)
    );

    logic [15:0] addr;
    logic        setup_rd;
    logic        access_wr;
    logic        full_word;
    logic        wr_bg;
    logic        wr_bg_clr;
    logic        wr_bg_set;
    logic        wr_bg_inv;
    logic        wr_cfg;
    logic [1:0]  bg_now;
    logic [1:0]  bg_mask;
    logic [1:0]  bg_sw;
    logic [31:0] read_value;

    assign addr      = paddr[15:0];
    assign setup_rd  = psel && !penable && !pwrite;
    assign access_wr = psel && penable && pwrite;
    // Key words only count when written whole; partial lanes are dropped
    assign full_word = (pstrb == 4'hf);

    // zero-wait slave that never flags an error
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    assign wr_bg     = access_wr && (addr == `OFF_BANDGAP);
    assign wr_bg_clr = access_wr && (addr == `OFF_BANDGAP_CLR);
    assign wr_bg_set = access_wr && (addr == `OFF_BANDGAP_SET);
    assign wr_bg_inv = access_wr && (addr == `OFF_BANDGAP_INV);
    // Protected register: only writable while unlocked, which reset or the key pair sets
    assign wr_cfg    = access_wr && (addr == `OFF_CFG_CTRL) &&
                       link.unlocked;

    // key writes go to the sequencer
    assign link.key_write = access_wr && full_word &&
                            (addr == `OFF_UNLOCK_KEY);
    assign link.key_data  = pwdata;
    assign link.osc_word  = osc_boot_word;
    assign link.prot_word = code_protect_word;

    assign bg_now  = {cur.conv_bg, cur.cmp_bg};
    assign bg_mask = {pwdata[`BG_CONV_BIT] && pstrb[0],
                      pwdata[`BG_CMP_BIT] && pstrb[0]};

    always_comb begin
        bg_sw = bg_now;
        if (wr_bg && pstrb[0])
            bg_sw = {pwdata[`BG_CONV_BIT], pwdata[`BG_CMP_BIT]};
        else if (wr_bg_clr)
            bg_sw = bg_now & ~bg_mask;
        else if (wr_bg_set)
            bg_sw = bg_now | bg_mask;
        else if (wr_bg_inv)
            bg_sw = bg_now ^ bg_mask;
    end

    always_comb begin
        read_value = 32'h00000000;
        case (addr)
            `OFF_BANDGAP, `OFF_BANDGAP_CLR, `OFF_BANDGAP_SET,
            `OFF_BANDGAP_INV: begin
                read_value[`BG_CONV_BIT] = cur.conv_bg;
                read_value[`BG_CMP_BIT]  = cur.cmp_bg;
            end
            `OFF_CFG_CTRL: begin
                read_value[`CFG_ERRDIS_BIT]              = cur.err_dis;
                read_value[`CFG_ARB_HI:`CFG_ARB_LO]      = cur.arb;
                read_value[`CFG_EXEC_HI:`CFG_EXEC_LO]    = cur.exec;
                read_value[`CFG_JTAG_BIT]                = cur.jtag;
                read_value[`CFG_RSVD_HI:`CFG_RSVD_LO]    = `CFG_RSVD_VAL;
            end
            `OFF_IDENTITY: read_value = {REVISION_CODE, PART_CODE};
            // only the status bit is readable
            `OFF_UNLOCK_KEY:
                read_value[`KEY_STATUS_BIT] = link.unlocked;
            `OFF_OSC_BOOT:  read_value = osc_boot_word;
            `OFF_CODE_PROT: read_value = code_protect_word;
            default: read_value = 32'h00000000;
        endcase
    end

    always_comb begin
        next_cur = cur;
        if (setup_rd)
            next_cur.rdata = read_value;

        // converter reference, hardware set wins over any clear
        next_cur.conv_bg = bg_sw[1];
        if (conv_bandgap_hw_clear)
            next_cur.conv_bg = 1'b0;
        if (conv_bandgap_hw_set)
            next_cur.conv_bg = 1'b1;
        next_cur.cmp_bg = bg_sw[0];
        if (cmp_bandgap_hw_clear)
            next_cur.cmp_bg = 1'b0;
        if (cmp_bandgap_hw_set)
            next_cur.cmp_bg = 1'b1;

        // debug enable taken from the strap once after reset
        if (!cur.strap_done) begin
            next_cur.jtag       = debug_port_strap;
            next_cur.strap_done = 1'b1;
        end

        if (wr_cfg) begin
            if (pstrb[3]) begin
                next_cur.err_dis = pwdata[`CFG_ERRDIS_BIT];
                // reserved arbitration code is not stored
                if (pwdata[`CFG_ARB_HI:`CFG_ARB_LO] != `ARB_RESERVED)
                    next_cur.arb = pwdata[`CFG_ARB_HI:`CFG_ARB_LO];
            end
            if (pstrb[2])
                next_cur.exec = pwdata[`CFG_EXEC_HI:`CFG_EXEC_LO];
            if (pstrb[0] && cur.strap_done)
                next_cur.jtag = pwdata[`CFG_JTAG_BIT];
        end

        next_cur.ram_base = `RAM_BASE_ADDR +
                            {14'h0000, cur.exec, `RAM_STEP_ZEROS};
        // Boot options are sampled so every boot option output leaves a flop
        next_cur.boot = link.decoded;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur.rdata      <= 32'h00000000;
            cur.conv_bg    <= 1'b0;
            cur.cmp_bg     <= 1'b0;
            cur.err_dis    <= 1'b0;
            cur.arb        <= 2'h0;
            cur.exec       <= 8'h00;
            cur.jtag       <= 1'b0;
            cur.strap_done <= 1'b0;
            cur.ram_base   <= `RAM_BASE_ADDR;
            cur.boot       <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign prdata = cur.rdata;

    assign clock_switch_enable      = cur.boot.clock_switch_en;
    assign fail_safe_monitor_enable = cur.boot.fail_safe_en;
    assign secondary_osc_crystal    = cur.boot.secondary_oscillator_crystal;
    assign clock_output_enable      = cur.boot.clock_output_en;
    assign primary_osc_mode         = cur.boot.primary_osc_mode;
    assign dual_speed_startup       = cur.boot.dual_speed_startup;
    assign secondary_osc_enable     = cur.boot.secondary_osc_enable;
    assign pll_source_select        = cur.boot.pll_from_fast_rc;
    assign oscillator_selection     = cur.boot.reset_clock;
    assign code_protect_active      = cur.boot.code_protect_on;
    assign bus_error_exception_enable = !cur.err_dis;
    assign bus_arbitration_mode     = sys_bank_pkg::arbitration_e'(cur.arb);
    assign ram_program_base         = cur.ram_base;
    assign debug_port_enable        = cur.jtag;
    assign converter_bandgap_enable = cur.conv_bg;
    assign comparator_bandgap_enable = cur.cmp_bg;
    assign system_unlocked          = link.unlocked;
endmodule

// >>> sim/bank_monitor.sv
// Port-level checker for the configuration bank
`timescale 1ns/1ps
`include "sys_bank_cfg.svh"
module bank_monitor #(
    parameter int ADDR_W = 16
) (
    input wire logic                       pclk,
    input wire logic                       presetn,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [ADDR_W-1:0]          paddr,
    input wire logic [31:0]                pwdata,
    input wire logic [3:0]                 pstrb,
    input wire logic                       pready,
    input wire logic                       pslverr,
    input wire logic [31:0]                osc_boot_word,
    input wire logic [31:0]                code_protect_word,
    input wire logic                       conv_bandgap_hw_set,
    input wire logic                       cmp_bandgap_hw_set,
    input wire logic                       cmp_bandgap_hw_clear,
    input wire logic                       clock_switch_enable,
    input wire logic                       fail_safe_monitor_enable,
    input wire sys_bank_pkg::reset_clock_e oscillator_selection,
    input wire logic                       code_protect_active,
    input wire logic                       bus_error_exception_enable,
    input wire logic [31:0]                ram_program_base,
    input wire logic                       converter_bandgap_enable,
    input wire logic                       comparator_bandgap_enable,
    input wire logic                       system_unlocked
);
    logic wr;
    logic key_wr;
    assign wr = psel && penable && pwrite;
    assign key_wr = wr && paddr == `OFF_UNLOCK_KEY && pstrb == 4'hf;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_no_error_a:
    assert property (pready && !pslverr) else $error("bus answer bad");
    ram_base_form_a:
    assert property (ram_program_base[31:18] == 14'h2800
        && ram_program_base[9:0] == 10'h000) else $error("ram base off");
    switch_monitor_a:
    assert property ($past(presetn) |-> {clock_switch_enable,
        fail_safe_monitor_enable} == $past(osc_boot_word[15:14]))
        else $error("clock switch decode");
    reset_clock_a:
    assert property ($past(presetn) |-> oscillator_selection ==
        ($past(osc_boot_word[2:0]) inside {3'h3, 3'h6, 3'h7} ? 3'h0
        : $past(osc_boot_word[2:0]))) else $error("reset clock decode");
    code_protect_a:
    assert property ($past(presetn) |-> code_protect_active ==
        !$past(code_protect_word[31])) else $error("protect decode");
    key_unlock_a:
    assert property (key_wr && pwdata == `KEY_FIRST ##3
        key_wr && pwdata == `KEY_SECOND |=> system_unlocked)
        else $error("key pair did not unlock");
    key_break_a:
    assert property (key_wr && pwdata != `KEY_SECOND |=> !system_unlocked)
        else $error("stray key left unlocked");
    locked_cfg_a:
    assert property (wr && paddr == `OFF_CFG_CTRL && !system_unlocked
        |=> $stable(bus_error_exception_enable) [*2])
        else $error("locked control changed");
    bandgap_set_a:
    assert property (conv_bandgap_hw_set |-> ##[1:2] converter_bandgap_enable)
        else $error("hardware set lost");
    bandgap_clear_a:
    assert property (cmp_bandgap_hw_clear && !cmp_bandgap_hw_set
        |-> ##[1:2] !comparator_bandgap_enable) else $error("clear lost");
    cover property (key_wr && pwdata == `KEY_SECOND);
    cover property (wr && paddr == `OFF_CFG_CTRL && !system_unlocked);
    cover property (wr && paddr == `OFF_BANDGAP_INV);
endmodule

// >>> sim/test_system_config_unlock_bank.sv
// Self-checking bench for the configuration bank
`timescale 1ns/1ps
`include "sys_bank_cfg.svh"
module test_system_config_unlock_bank;
    // Arbitrary identity value for this build
    localparam logic [31:0] ID = 32'h20000123;
    logic                              pclk, presetn, psel, penable, pwrite;
    logic [15:0]                       paddr;
    logic [31:0]                       pwdata, prdata, osc_word, prot_word, rd;
    logic [3:0]                        pstrb;
    logic                              pready, pslverr, strap;
    logic                              conv_set, conv_clr, cmp_set, cmp_clr;
    logic                              cs_en, fs_en, secondary_oscillator_xtal, clock_output_pin_en;
    logic                              dual, secondary_oscillator_en, pll_src, cp_on, berr_en;
    logic                              dbg_en, conv_bg, cmp_bg, unlocked;
    logic [31:0]                       ram_base;
    sys_bank_pkg::primary_osc_mode_e   pmode;
    sys_bank_pkg::reset_clock_e        osc_sel;
    sys_bank_pkg::arbitration_e        arb;
    int                                fail_count, comparisons;
    system_config_unlock_bank #(
        .ADDR_W(16), .REVISION_CODE(ID[31:28]), .PART_CODE(ID[27:0])
    ) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .osc_boot_word(osc_word), .code_protect_word(prot_word),
        .debug_port_strap(strap), .conv_bandgap_hw_set(conv_set),
        .conv_bandgap_hw_clear(conv_clr), .cmp_bandgap_hw_set(cmp_set),
        .cmp_bandgap_hw_clear(cmp_clr), .clock_switch_enable(cs_en),
        .fail_safe_monitor_enable(fs_en), .secondary_osc_crystal(secondary_oscillator_xtal),
        .clock_output_enable(clock_output_pin_en), .primary_osc_mode(pmode),
        .dual_speed_startup(dual), .secondary_osc_enable(secondary_oscillator_en),
        .pll_source_select(pll_src), .oscillator_selection(osc_sel),
        .code_protect_active(cp_on), .bus_error_exception_enable(berr_en),
        .bus_arbitration_mode(arb), .ram_program_base(ram_base),
        .debug_port_enable(dbg_en), .converter_bandgap_enable(conv_bg),
        .comparator_bandgap_enable(cmp_bg), .system_unlocked(unlocked)
    );
    task results;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Request held until pready is seen high at a rising edge
    task apb(input logic w, input logic [15:0] a, input logic [31:0] d,
             input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [15:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hf);
    endtask
    task rd_chk(input logic [15:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 4'h0);
        chk(rd, exp);
    endtask
    // Registered outputs trail the write edge, so let them land first
    task settle;
        repeat (3) @(posedge pclk);
    endtask
    task t_reset;
        rd_chk(`OFF_CFG_CTRL, 32'hb);
        rd_chk(`OFF_UNLOCK_KEY, 32'h1);
        rd_chk(`OFF_BANDGAP, 32'h0);
        wr(`OFF_IDENTITY, 32'h0);
        rd_chk(`OFF_IDENTITY, ID);
        wr(16'h1000, 32'hffffffff);
        rd_chk(16'h1000, 32'h0);
        chk(32'({dbg_en, berr_en, unlocked}), 32'h7);
    endtask
    task t_cfg;
        wr(`OFF_CFG_CTRL, 32'h0a050000);
        settle;
        rd_chk(`OFF_CFG_CTRL, 32'h0a050003);
        chk(32'({berr_en, arb, dbg_en}), 32'h4);
        chk(ram_base, 32'ha0001400);
        // Reserved arbitration code must leave the old mode in place
        wr(`OFF_CFG_CTRL, 32'h0bff0008);
        settle;
        rd_chk(`OFF_CFG_CTRL, 32'h0aff000b);
        chk(32'({berr_en, arb, dbg_en}), 32'h5);
        chk(ram_base, 32'ha003fc00);
        for (int i = 0; i < 3; i++) begin
            wr(`OFF_CFG_CTRL, {6'h0, 2'(i), 24'h0});
            settle;
            chk(32'({berr_en, arb}), 32'h4 + i);
        end
        chk(ram_base, `RAM_BASE_ADDR);
    endtask
    task t_key;
        wr(`OFF_UNLOCK_KEY, 32'h0);
        rd_chk(`OFF_UNLOCK_KEY, 32'h0);
        wr(`OFF_CFG_CTRL, 32'h08000000);
        rd_chk(`OFF_CFG_CTRL, 32'h02000003);
        wr(`OFF_UNLOCK_KEY, `KEY_FIRST);
        wr(`OFF_BANDGAP, 32'h0);
        wr(`OFF_UNLOCK_KEY, `KEY_SECOND);
        rd_chk(`OFF_UNLOCK_KEY, 32'h1);
        wr(`OFF_UNLOCK_KEY, `KEY_FIRST);
        wr(`OFF_UNLOCK_KEY, 32'h12345678);
        wr(`OFF_UNLOCK_KEY, `KEY_SECOND);
        settle;
        chk(32'(unlocked), 32'h0);
        wr(`OFF_UNLOCK_KEY, `KEY_FIRST);
        wr(`OFF_UNLOCK_KEY, `KEY_SECOND);
        settle;
        chk(32'(unlocked), 32'h1);
    endtask
    task t_band;
        wr(`OFF_BANDGAP, 32'hffffffff);
        rd_chk(`OFF_BANDGAP, 32'h6);
        wr(`OFF_BANDGAP_CLR, 32'h4);
        rd_chk(`OFF_BANDGAP, 32'h2);
        wr(`OFF_BANDGAP_SET, 32'h4);
        rd_chk(`OFF_BANDGAP, 32'h6);
        wr(`OFF_BANDGAP_INV, 32'h6);
        rd_chk(`OFF_BANDGAP_INV, 32'h0);
        conv_set <= 1'b1;
        cmp_clr <= 1'b1;
        @(posedge pclk);
        conv_set <= 1'b0;
        cmp_clr <= 1'b0;
        settle;
        chk(32'({conv_bg, cmp_bg}), 32'h2);
        conv_clr <= 1'b1;
        cmp_set <= 1'b1;
        @(posedge pclk);
        conv_clr <= 1'b0;
        cmp_set <= 1'b0;
        settle;
        chk(32'({conv_bg, cmp_bg}), 32'h1);
    endtask
    task t_boot;
        logic [2:0] c;
        for (int i = 0; i < 8; i++) begin
            c = 3'(i);
            osc_word <= {16'hffff, c[1:0], 1'b1, c[2], 1'b1, c[0], c[1:0],
                         c[2], c[1], 1'b1, c[0], 1'b1, c};
            prot_word <= {c[0], 31'h7fffffff};
            settle;
            chk(32'(osc_sel), (c == 3'h3 || c[2:1] == 2'h3) ? 0 : c);
            chk(32'({cs_en, fs_en, secondary_oscillator_xtal, clock_output_pin_en, pmode}),
                32'({c[1:0], c[2], !c[0], c[1:0]}));
            chk(32'({dual, secondary_oscillator_en, pll_src, cp_on}),
                32'({c, !c[0]}));
        end
    endtask
    // Mid-run reset with the strap low: lock and debug enable start afresh
    task t_strap;
        wr(`OFF_UNLOCK_KEY, 32'h0);
        strap <= 1'b0;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        settle;
        rd_chk(`OFF_CFG_CTRL, 32'h3);
        chk(32'({dbg_en, berr_en, unlocked}), 32'h3);
    endtask
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, conv_set, conv_clr} = '0;
        {cmp_set, cmp_clr, paddr, pwdata, pstrb} = '0;
        osc_word = 32'hffffffff;
        prot_word = 32'hffffffff;
        strap = 1'b1;
        fail_count = 0;
        comparisons = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        settle;
        t_reset;
        t_cfg;
        t_key;
        t_band;
        t_boot;
        t_strap;
        results;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        results;
    end
endmodule
bind system_config_unlock_bank bank_monitor #(.ADDR_W(ADDR_W)) u_mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .pslverr(pslverr), .osc_boot_word(osc_boot_word),
    .code_protect_word(code_protect_word),
    .conv_bandgap_hw_set(conv_bandgap_hw_set),
    .cmp_bandgap_hw_set(cmp_bandgap_hw_set),
    .cmp_bandgap_hw_clear(cmp_bandgap_hw_clear),
    .clock_switch_enable(clock_switch_enable),
    .fail_safe_monitor_enable(fail_safe_monitor_enable),
    .oscillator_selection(oscillator_selection),
    .code_protect_active(code_protect_active),
    .bus_error_exception_enable(bus_error_exception_enable),
    .ram_program_base(ram_program_base),
    .converter_bandgap_enable(converter_bandgap_enable),
    .comparator_bandgap_enable(comparator_bandgap_enable),
    .system_unlocked(system_unlocked)
);
